//--- inc/clu_pkg.sv
// package: register map, field layout and types of the configurable logic unit
`default_nettype none
package clu_pkg;

  // ************************
  // register byte addresses
  // ************************
  localparam logic [7:0] ADDR_GLOBAL   = 8'h00; // global_control
  localparam logic [7:0] ADDR_SEQ_BASE = 8'h04; // sequential_control, pair 0
  localparam logic [7:0] SEQ_STRIDE    = 8'h04;
  localparam logic [7:0] ADDR_LUT_BASE = 8'h10; // lut_control_a, unit 0
  localparam logic [7:0] LUT_STRIDE    = 8'h08; // lut_control_b sits at +4
  localparam logic [7:0] LUT_B_OFS     = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h30; // live outputs, read only

  // ************************
  // field positions
  // ************************
  localparam int BIT_EN         = 0; // enable (global and per unit)
  localparam int BIT_LUT_CLOCK_SOURCE_SELECT     = 1; // lut_clock_source_select
  localparam int BIT_EDGE       = 2; // edge_detect_enable
  localparam int FILT_LSB       = 4; // filter select, 2 bits
  localparam int SEQ_STATUS_LSB = 8; // sequential outputs in status word

  // filter options
  localparam logic [1:0] FILT_OFF  = 2'h0;
  localparam logic [1:0] FILT_SYNC = 2'h1;
  localparam logic [1:0] FILT_FILT = 2'h2;

  // per-unit control, lut_control_a and lut_control_b together
  typedef struct packed {
    logic [7:0] pattern; // lookup_pattern
    logic [1:0] filt;
    logic       edge_en;
    logic       lut_clock_source_select;
    logic       en;
  } clu_lut_ctrl_t;

  localparam clu_lut_ctrl_t LUT_CTRL_RST = '0;

  // sequential_function_select
  typedef enum logic [2:0] {
    SEQ_OFF, SEQ_DFF, SEQ_JK, SEQ_DLATCH, SEQ_RS
  } clu_seq_t;

  function automatic logic [7:0] lut_a_addr(input int i);
    return 8'(ADDR_LUT_BASE + LUT_STRIDE * i);
  endfunction

  function automatic logic [7:0] seq_addr(input int p);
    return 8'(ADDR_SEQ_BASE + SEQ_STRIDE * p);
  endfunction

endpackage

`default_nettype wire

//--- rtl/clu_top.sv
// configurable logic unit: lookup units, filters, edge detectors, sequencers
`timescale 1ns/1ps
`default_nettype none

// Operation
// - sequencer select writable only while even unit off
// - unit control fields writable only while unit off or by an enabling write; pattern only while off
// - enabling write updates fields; disabling write does not
// - keeps running during processor debug halt
// - edge detector pulses on rising input edge
// - edge_detect_enable bit switches detector on/off
// - edge state cleared one cycle after disable
// - pair sequencer: D, JK, D-latch, RS
// - sequencer fed by lut, filter or edge output
// - clock from peripheral clock or input line two
// - sequencer clocked like its even unit
module clu_top
  import clu_pkg::*;
#(
  parameter int NUM_LUTS = 4 // even, at most 4 with this map
) (
  input  wire logic                      ref_clk_i, // 100 MHz clock
  input  wire logic                      rst_i,     // sync, active high
  input  wire logic                      psel_i,    // apb select
  input  wire logic                      penable_i, // apb enable
  input  wire logic                      pwrite_i,  // apb direction
  input  wire logic [7:0]                paddr_i,   // apb byte address
  input  wire logic [31:0]               pwdata_i,  // apb write data
  input  wire logic [NUM_LUTS-1:0][2:0]  lut_in_i,  // unit inputs
  output logic      [31:0]               prdata_o,  // apb read data
  output logic                           pready_o,  // apb ready
  output logic                           pslverr_o, // unmapped address
  output logic      [NUM_LUTS-1:0]       lut_out_o  // unit outputs
);

  localparam int NP = NUM_LUTS / 2;

  // ************************
  // state
  // ************************
  logic          glob_en;
  clu_lut_ctrl_t ctrl [NUM_LUTS];
  clu_seq_t      seq_sel [NP];
  logic [NUM_LUTS-1:0] act;       // unit really running
  logic [NUM_LUTS-1:0] tick;      // unit clock event
  logic [NUM_LUTS-1:0] raw;       // lookup result
  logic [NUM_LUTS-1:0] pre;       // after filter stage
  logic [NUM_LUTS-1:0] in2_d;     // previous input line two
  logic [NUM_LUTS-1:0] s1;
  logic [NUM_LUTS-1:0] s2;
  logic [NUM_LUTS-1:0] filt;
  logic [NUM_LUTS-1:0] edge_prev;
  logic [NUM_LUTS-1:0] stage;     // unit result feeding sequencer
  logic [NP-1:0]       seq_q;
  logic                acc;
  logic                wr_do;
  logic                hit;
  logic [31:0]         next_rdata;

  // ************************
  // apb slave
  // ************************
  // one wait state keeps prdata and pready straight from flops
  assign acc   = psel_i & penable_i;
  assign wr_do = acc & pready_o & pwrite_i;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= acc & ~pready_o;
    end
  end

  // read data and error captured in the wait cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prdata_o  <= '0;
      pslverr_o <= 1'b0;
    end else if (acc & ~pready_o) begin
      prdata_o  <= pwrite_i ? 32'h0000_0000 : next_rdata;
      pslverr_o <= ~hit;
    end
  end

  // address decode and read mux
  always_comb begin
    next_rdata = '0;
    hit        = 1'b0;
    if (paddr_i == ADDR_GLOBAL) begin
      hit           = 1'b1;
      next_rdata[BIT_EN] = glob_en;
    end
    if (paddr_i == ADDR_STATUS) begin
      hit = 1'b1;
      next_rdata[NUM_LUTS-1:0]         = lut_out_o;
      next_rdata[SEQ_STATUS_LSB +: NP] = seq_q;
    end
    for (int i = 0; i < NUM_LUTS; i++) begin
      if (paddr_i == lut_a_addr(i)) begin
        hit = 1'b1;
        next_rdata[BIT_EN]          = ctrl[i].en;
        next_rdata[BIT_LUT_CLOCK_SOURCE_SELECT]      = ctrl[i].lut_clock_source_select;
        next_rdata[BIT_EDGE]        = ctrl[i].edge_en;
        next_rdata[FILT_LSB +: 2]   = ctrl[i].filt;
      end
      if (paddr_i == 8'(lut_a_addr(i) + LUT_B_OFS)) begin
        hit = 1'b1;
        next_rdata[7:0] = ctrl[i].pattern;
      end
    end
    for (int p = 0; p < NP; p++) begin
      if (paddr_i == seq_addr(p)) begin
        hit = 1'b1;
        next_rdata[2:0] = seq_sel[p];
      end
    end
  end

  // global enable; no halt input exists, so debug halts never stop it
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      glob_en <= 1'b0;
    end else if (wr_do && paddr_i == ADDR_GLOBAL) begin
      glob_en <= pwdata_i[BIT_EN];
    end
  end

  // unit control: enable always writable, the rest guarded
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_LUTS; i++) begin
        ctrl[i] <= LUT_CTRL_RST;
      end
    end else begin
      for (int i = 0; i < NUM_LUTS; i++) begin
        if (wr_do && paddr_i == lut_a_addr(i)) begin
          ctrl[i].en <= pwdata_i[BIT_EN];
          if (!ctrl[i].en || pwdata_i[BIT_EN]) begin
            ctrl[i].lut_clock_source_select  <= pwdata_i[BIT_LUT_CLOCK_SOURCE_SELECT];
            ctrl[i].edge_en <= pwdata_i[BIT_EDGE];
            ctrl[i].filt    <= pwdata_i[FILT_LSB +: 2];
          end
        end
        if (wr_do && paddr_i == 8'(lut_a_addr(i) + LUT_B_OFS) && !ctrl[i].en) begin
          ctrl[i].pattern <= pwdata_i[7:0];
        end
      end
    end
  end

  // sequencer select, locked while the even unit's enable bit is set
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < NP; p++) begin
        seq_sel[p] <= SEQ_OFF;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (wr_do && paddr_i == seq_addr(p) && !ctrl[2*p].en) begin
          seq_sel[p] <= clu_seq_t'(pwdata_i[2:0]);
        end
      end
    end
  end

  // ************************
  // lookup units
  // ************************
  for (genvar i = 0; i < NUM_LUTS; i++) begin : g_unit
    assign act[i] = glob_en & ctrl[i].en;
    assign raw[i] = ctrl[i].pattern[lut_in_i[i]];
    // input line two used as a clock by edge detection on it
    assign tick[i] = ctrl[i].lut_clock_source_select ? (lut_in_i[i][2] & ~in2_d[i]) : 1'b1;
    assign pre[i] = (ctrl[i].filt == FILT_OFF)  ? raw[i] :
                    (ctrl[i].filt == FILT_SYNC) ? s2[i]  : filt[i];

    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        in2_d[i] <= 1'b0;
      end else begin
        in2_d[i] <= lut_in_i[i][2];
      end
    end

    // filter: output follows only after two equal samples
    always_ff @(posedge ref_clk_i) begin
      if (rst_i || !act[i]) begin
        s1[i]   <= 1'b0;
        s2[i]   <= 1'b0;
        filt[i] <= 1'b0;
      end else if (tick[i]) begin
        s1[i] <= raw[i];
        s2[i] <= s1[i];
        if (s1[i] == s2[i]) begin
          filt[i] <= s2[i];
        end
      end
    end

    // edge detector; rising edges only, falling needs an inverted pattern
    always_ff @(posedge ref_clk_i) begin
      if (rst_i || !act[i]) begin
        edge_prev[i] <= 1'b0;
        stage[i]     <= 1'b0;
      end else if (tick[i]) begin
        edge_prev[i] <= pre[i];
        stage[i] <= ctrl[i].edge_en ? (pre[i] & ~edge_prev[i]) : pre[i];
      end
    end

    // pin output; even unit shows its sequencer when one is chosen
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        lut_out_o[i] <= 1'b0;
      end else if (i % 2 == 0 && seq_sel[i/2] inside {SEQ_DFF, SEQ_JK, SEQ_DLATCH, SEQ_RS}) begin
        lut_out_o[i] <= seq_q[i/2];
      end else begin
        lut_out_o[i] <= stage[i];
      end
    end

    sequence s_off;
      !act[i] [*2];
    endsequence

    chk_edge_clear : assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !act[i] |=> !edge_prev[i] && !stage[i])
      else $error("edge state not cleared after disable");
    chk_edge_single : assert property (@(posedge ref_clk_i) disable iff (rst_i)
      act[i] && ctrl[i].edge_en && tick[i] && stage[i] |=> !stage[i])
      else $error("edge pulse longer than one unit clock");
    chk_clk_select : assert property (@(posedge ref_clk_i) disable iff (rst_i)
      act[i] && ctrl[i].lut_clock_source_select && !tick[i] |=> $stable(stage[i]))
      else $error("unit moved without input line two edge");
    chk_off_zero : assert property (@(posedge ref_clk_i) disable iff (rst_i)
      s_off |=> !lut_out_o[i])
      else $error("disabled unit output not zero");
    chk_lut_guard : assert property (@(posedge ref_clk_i) disable iff (rst_i)
      wr_do && paddr_i == lut_a_addr(i) && ctrl[i].en && !pwdata_i[BIT_EN]
      |=> $stable(ctrl[i].filt) && $stable(ctrl[i].edge_en))
      else $error("disabling write changed guarded fields");
    chk_lut_enwr : assert property (@(posedge ref_clk_i) disable iff (rst_i)
      wr_do && paddr_i == lut_a_addr(i) && pwdata_i[BIT_EN]
      |=> ctrl[i].edge_en == $past(pwdata_i[BIT_EDGE]))
      else $error("enabling write did not update fields");
  end

  // ************************
  // sequencers, one per pair
  // ************************
  for (genvar p = 0; p < NP; p++) begin : g_seq
    logic a;
    logic b;
    assign a = stage[2*p];
    assign b = stage[2*p+1];

    // ticks with the even unit; latches update once per tick
    always_ff @(posedge ref_clk_i) begin
      if (rst_i || !act[2*p]) begin
        seq_q[p] <= 1'b0;
      end else if (tick[2*p]) begin
        unique case (seq_sel[p])
          SEQ_DFF: seq_q[p] <= b ? 1'b0 : a; // odd input clears
          SEQ_JK: begin
            if (a && b) begin
              seq_q[p] <= ~seq_q[p];
            end else if (a) begin
              seq_q[p] <= 1'b1;
            end else if (b) begin
              seq_q[p] <= 1'b0;
            end
          end
          SEQ_DLATCH: begin
            if (b) begin
              seq_q[p] <= a; // odd input is the gate
            end
          end
          SEQ_RS: begin
            if (b) begin
              seq_q[p] <= 1'b0; // reset wins
            end else if (a) begin
              seq_q[p] <= 1'b1;
            end
          end
          SEQ_OFF: seq_q[p] <= 1'b0;
          default: seq_q[p] <= 1'b0; // undefined select codes
        endcase
      end
    end

    chk_seq_guard : assert property (@(posedge ref_clk_i) disable iff (rst_i)
      wr_do && paddr_i == seq_addr(p) && ctrl[2*p].en |=> $stable(seq_sel[p]))
      else $error("sequencer select changed while enabled");
    chk_seq_clock : assert property (@(posedge ref_clk_i) disable iff (rst_i)
      act[2*p] && !tick[2*p] |=> $stable(seq_q[p]))
      else $error("sequencer moved without even unit clock");
  end

  chk_ready_wait : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    acc && !pready_o |=> pready_o ##1 !pready_o)
    else $error("apb ready not one wait state");

endmodule // clu_top

`default_nettype wire

//--- sim/clu_pin_model.sv
// model of the pins and peripheral signals that feed the unit inputs
`timescale 1ns/1ps
`default_nettype none
module clu_pin_model #(
  parameter int N = 4 // number of units
) (
  input  wire logic              ref_clk_i, // system clock
  input  wire logic [N-1:0][2:0] lvl_i,     // wanted pin levels
  output logic      [N-1:0][2:0] lut_in_o   // levels seen by the units
);
  // pins arrive through a synchroniser, so a level moves one edge late
  always_ff @(posedge ref_clk_i) begin
    lut_in_o <= lvl_i;
  end
endmodule // clu_pin_model
`default_nettype wire

//--- sim/clu_top_test.sv
// self-checking testbench of the configurable logic unit
`timescale 1ns/1ps
`default_nettype none
module clu_top_test;
  import clu_pkg::*;
  localparam int N = 4;
  logic              ref_clk_i, rst_i, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [N-1:0][2:0] lvl, lut_in;
  logic [N-1:0]      lut_out;
  int                error_cnt, checks, cyc, cnt;
  localparam logic [7:0] LA0 = 8'h10, LB0 = 8'h14, LA1 = 8'h18, LB1 = 8'h1C;

  clu_top #(.NUM_LUTS(N)) i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .lut_in_i(lut_in), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .lut_out_o(lut_out));
  clu_pin_model #(.N(N)) i_pins (.ref_clk_i(ref_clk_i), .lvl_i(lvl), .lut_in_o(lut_in));

  // ****************
  // common tasks
  // ****************
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t bit %b expected %b", $time, got, exp);
    end
  endtask
  // one apb transfer; the wait ends only on pready or the bench timeout
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_word(rd, exp);
  endtask
  task automatic wait_out(input int i, input logic v);
    for (int k = 0; k < 20 && lut_out[i] !== v; k++) @(posedge ref_clk_i);
    chk_bit(lut_out[i], v);
  endtask
  task automatic finish_test();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    rdc(ADDR_GLOBAL, 32'h0);
    rdc(LA0, 32'h0);
    rdc(ADDR_STATUS, 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk_bit(err, 1'b1);
    chk_word(rd, 32'h0);
  endtask
  task automatic t_walk();
    wr(ADDR_GLOBAL, 32'h1);
    wr(LB0, 32'h80);
    wr(LA0, 32'h1);
    lvl[0] <= 3'h7;
    wait_out(0, 1'b1);
    rdc(ADDR_STATUS, 32'h1);
    wr(LA0, 32'h0);
    wait_out(0, 1'b0);
    lvl[0] <= 3'h0;
  endtask
  // guarded fields: pattern, flags and sequencer select
  task automatic t_guard();
    wr(LA0, 32'h1);
    wr(LB0, 32'h01);
    rdc(LB0, 32'h80);
    wr(LA0, 32'h4);
    rdc(LA0, 32'h0);
    wr(LA0, 32'h5);
    rdc(LA0, 32'h5);
    wr(ADDR_SEQ_BASE, 32'h1);
    rdc(ADDR_SEQ_BASE, 32'h0);
    wr(LA0, 32'h0);
  endtask
  // counts high cycles of one unit output over twenty clocks
  task automatic count_hi(input int i);
    cnt = 0;
    repeat (20) begin
      @(posedge ref_clk_i);
      if (lut_out[i] === 1'b1) cnt++;
    end
  endtask
  // counts high cycles of unit 0 after one input change
  task automatic edge_case(input logic [7:0] pat, input logic [7:0] ctl,
                           input logic l0, input logic l1);
    wr(LA0, 32'h0);
    lvl[0] <= {2'b00, l0};
    wr(LB0, {24'h0, pat});
    wr(LA0, {24'h0, ctl});
    repeat (8) @(posedge ref_clk_i);
    lvl[0] <= {2'b00, l1};
    count_hi(0);
  endtask
  task automatic t_edge();
    edge_case(8'hAA, 8'h15, 1'b0, 1'b1);
    chk_word(cnt, 32'd1);
    edge_case(8'h55, 8'h15, 1'b1, 1'b0);
    chk_word(cnt, 32'd1);
    edge_case(8'hAA, 8'h25, 1'b0, 1'b1);
    chk_word(cnt, 32'd1);
    edge_case(8'hAA, 8'h01, 1'b0, 1'b1);
    chk_bit(cnt > 8, 1'b1);
    wr(LA0, 32'h0);
  endtask
  task automatic t_seq();
    wr(ADDR_SEQ_BASE, 32'h1);
    wr(LB0, 32'hAA);
    wr(LB1, 32'hAA);
    wr(LA1, 32'h1);
    wr(LA0, 32'h1);
    lvl[0] <= 3'h1;
    wait_out(0, 1'b1);
    lvl[0] <= 3'h0;
    wait_out(0, 1'b0);
    wr(LA0, 32'h0);
    wr(ADDR_SEQ_BASE, 32'h4);
    wr(LA0, 32'h1);
    lvl[0] <= 3'h1;
    wait_out(0, 1'b1);
    lvl[0] <= 3'h0;
    repeat (10) @(posedge ref_clk_i);
    rdc(ADDR_STATUS, 32'h101);
    lvl[1] <= 3'h1;
    wait_out(0, 1'b0);
    lvl[1] <= 3'h0;
    // jk: set, reset, then toggle every clock while both inputs are high
    wr(LA0, 32'h0);
    wr(ADDR_SEQ_BASE, 32'h2);
    wr(LA0, 32'h1);
    lvl[0] <= 3'h1;
    wait_out(0, 1'b1);
    lvl[0] <= 3'h0;
    lvl[1] <= 3'h1;
    wait_out(0, 1'b0);
    lvl[0] <= 3'h1;
    repeat (4) @(posedge ref_clk_i);
    count_hi(0);
    chk_word(cnt, 32'd10);
    lvl[0] <= 3'h0;
    lvl[1] <= 3'h0;
    // gated latch: odd unit is the gate, even unit the data
    wr(LA0, 32'h0);
    wr(ADDR_SEQ_BASE, 32'h3);
    wr(LA0, 32'h1);
    lvl[0] <= 3'h1;
    repeat (10) @(posedge ref_clk_i);
    chk_bit(lut_out[0], 1'b0);
    lvl[1] <= 3'h1;
    wait_out(0, 1'b1);
    lvl[0] <= 3'h0;
    wait_out(0, 1'b0);
    lvl[1] <= 3'h0;
    repeat (4) @(posedge ref_clk_i);
    lvl[0] <= 3'h1;
    repeat (10) @(posedge ref_clk_i);
    chk_bit(lut_out[0], 1'b0);
    lvl[0] <= 3'h0;
    wr(LA0, 32'h0);
    wr(LA1, 32'h0);
    wr(ADDR_SEQ_BASE, 32'h0);
  endtask
  // units 1 to 3 on their own output pins, plain lookup
  task automatic t_units();
    for (int i = 1; i < N; i++) begin
      wr(8'(lut_a_addr(i) + LUT_B_OFS), 32'h80);
      wr(lut_a_addr(i), 32'h1);
      lvl[i] <= 3'h7;
      wait_out(i, 1'b1);
      wr(lut_a_addr(i), 32'h0);
      wait_out(i, 1'b0);
      lvl[i] <= 3'h0;
    end
  endtask
  // second reset in mid-run clears controls and outputs
  task automatic t_rerun();
    rst_i <= 1'b1;
    lvl   <= '0;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    chk_bit(lut_out[0], 1'b0);
    rdc(ADDR_GLOBAL, 32'h0);
    rdc(LA0, 32'h0);
  endtask
  task automatic t_lut_clock_source_select();
    wr(ADDR_GLOBAL, 32'h0);
    wr(LA0, 32'h3);
    wr(ADDR_GLOBAL, 32'h1);
    lvl[0] <= 3'h1;
    repeat (10) @(posedge ref_clk_i);
    chk_bit(lut_out[0], 1'b0);
    lvl[0] <= 3'h5;
    wait_out(0, 1'b1);
  endtask

  // ****************
  // clock, timeout, main
  // ****************
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // all scenarios fit well inside 5000 cycles
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    rst_i = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; lvl = '0;
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_walk();
    t_units();
    t_guard();
    t_edge();
    t_seq();
    t_lut_clock_source_select();
    t_rerun();
    finish_test();
  end
endmodule // clu_top_test
`default_nettype wire
